// file: src/autobaud_defines.svh
`ifndef AUTOBAUD_DEFINES_SVH
`define AUTOBAUD_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define AXI_AW 8
`define OFS_CON 8'h00
`define OFS_BG 8'h04
`define OFS_FDV 8'h08
`define OFS_RBUF 8'h0C
`define OFS_IST 8'h10
`define OFS_IMASK 8'h14
`define OFS_DET 8'h18
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
////////////////////////////////////////////////////////////////////////////////
// Channel control register layout
`define CON_W 16
`define CON_RST 16'h0000
`define CON_M_LSB 0
`define CON_M_MSB 2
`define CON_ODD 3
`define CON_FEN 4
`define CON_PEN 5
`define CON_OEN 6
`define CON_FE 8
`define CON_PE 9
`define CON_OE 10
`define CON_FLAGS 16'h0700
////////////////////////////////////////////////////////////////////////////////
// Frame mode codes
`define M_SYNC 3'h0
`define M_8N 3'h1
`define M_7P 3'h3
`define M_8P 3'h7
////////////////////////////////////////////////////////////////////////////////
// Other widths and reset values
`define BG_W 13
`define BG_RST 13'h0000
`define FDV_W 9
`define FDV_RST 9'h000
`define RX_W 9
`define RX_RST 9'h000
`define IDX_W 4
`define DF_W 14
`define DET_DF_LSB 16
`define IRQ_W 3
`define IRQ_RST 3'h0
`define IRQ_RX 0
`define IRQ_ERR 1
`define IRQ_DET 2
`define EVENT_CYCLES 2
`define CNT_W 4
////////////////////////////////////////////////////////////////////////////////
// Rate table: reload values and divide factors of the prescaled clock
`define RATE_COUNT 9
`define BG_BR0 13'h0002
`define BG_BR1 13'h0005
`define BG_BR2 13'h000B
`define BG_BR3 13'h0011
`define BG_BR4 13'h0023
`define BG_BR5 13'h0047
`define BG_BR6 13'h008F
`define BG_BR7 13'h011F
`define BG_BR8 13'h023F
`define DF_BR0 14'h0030
`define DF_BR1 14'h0060
`define DF_BR2 14'h00C0
`define DF_BR3 14'h0120
`define DF_BR4 14'h0240
`define DF_BR5 14'h0480
`define DF_BR6 14'h0900
`define DF_BR7 14'h1200
`define DF_BR8 14'h2400
`endif

// file: src/autobaud_pkg.sv
`include "autobaud_defines.svh"
package autobaud_pkg;
	typedef enum logic [2:0] {
		FRAME_7_EVEN = 3'h0,
		FRAME_7_ODD = 3'h1,
		FRAME_8_EVEN = 3'h2,
		FRAME_8_ODD = 3'h3,
		FRAME_8_NONE = 3'h4
	} det_frame_t;

	typedef struct packed {
		logic ev;
		logic [`CNT_W-1:0] cnt;
	} stretch_state_t;

	typedef struct packed {
		logic [`CON_W-1:0] con;
		logic [`BG_W-1:0] bg;
		logic [`FDV_W-1:0] fractional_divide_value;
		logic [`RX_W-1:0] rbuf;
		logic rbuf_full;
		logic [`IRQ_W-1:0] ist;
		logic [`IRQ_W-1:0] imask;
		logic [`IDX_W-1:0] det_idx;
		logic [`DF_W-1:0] det_df;
		logic aw_got;
		logic [`AXI_AW-1:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} core_state_t;
endpackage : autobaud_pkg

// file: src/event_stretch.sv
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
module event_stretch #(
	parameter int LEN = `EVENT_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Trigger and stretched event
	input wire logic trig,
	output logic ev
);
	autobaud_pkg::stretch_state_t q;
	autobaud_pkg::stretch_state_t d;

	if (LEN < 1 || LEN > 15) begin : g_bad_len
		$error("event_stretch: LEN out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Holds the event high for LEN clocks from the edge after the trigger
	always_comb
	begin
		d = q;
		if (trig)
		begin
			d.ev = 1'b1;
			d.cnt = `CNT_W'(LEN - 1);
		end
		else if (q.cnt != '0)
		begin
			d.cnt = q.cnt - `CNT_W'(1);
		end
		else
		begin
			d.ev = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign ev = q.ev;
endmodule : event_stretch
`default_nettype wire

// file: src/detect_result_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
module detect_result_map (
	// Detection result
	input wire logic [`IDX_W-1:0] rate_index,
	input wire logic [2:0] frame,
	// Values to load
	output logic [`BG_W-1:0] reload,
	output logic [`DF_W-1:0] divide_factor,
	output logic [2:0] mode,
	output logic odd,
	output logic valid
);
	logic rate_ok;
	logic frame_ok;

	////////////////////////////////////////////////////////////////////////////////
	// Rate index to reload value and divide factor
	always_comb
	begin
		rate_ok = 1'b1;
		case (rate_index)
			`IDX_W'(0): begin reload = `BG_BR0; divide_factor = `DF_BR0; end
			`IDX_W'(1): begin reload = `BG_BR1; divide_factor = `DF_BR1; end
			`IDX_W'(2): begin reload = `BG_BR2; divide_factor = `DF_BR2; end
			`IDX_W'(3): begin reload = `BG_BR3; divide_factor = `DF_BR3; end
			`IDX_W'(4): begin reload = `BG_BR4; divide_factor = `DF_BR4; end
			`IDX_W'(5): begin reload = `BG_BR5; divide_factor = `DF_BR5; end
			`IDX_W'(6): begin reload = `BG_BR6; divide_factor = `DF_BR6; end
			`IDX_W'(7): begin reload = `BG_BR7; divide_factor = `DF_BR7; end
			`IDX_W'(8): begin reload = `BG_BR8; divide_factor = `DF_BR8; end
			default:
			begin
				reload = `BG_RST;
				divide_factor = '0;
				rate_ok = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame type to mode field and parity polarity
	always_comb
	begin
		frame_ok = 1'b1;
		case (frame)
			autobaud_pkg::FRAME_7_EVEN: begin mode = `M_7P; odd = 1'b0; end
			autobaud_pkg::FRAME_7_ODD: begin mode = `M_7P; odd = 1'b1; end
			autobaud_pkg::FRAME_8_EVEN: begin mode = `M_8P; odd = 1'b0; end
			autobaud_pkg::FRAME_8_ODD: begin mode = `M_8P; odd = 1'b1; end
			autobaud_pkg::FRAME_8_NONE: begin mode = `M_8N; odd = 1'b0; end
			default:
			begin
				mode = `M_SYNC;
				odd = 1'b0;
				frame_ok = 1'b0;
			end
		endcase
	end

	assign valid = rate_ok && frame_ok;
endmodule : detect_result_map
`default_nettype wire

// file: src/autobaud_rx_check.sv
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
// Function
// - Nine detectable rates are prescaled clock divided by 48 up to 9216.
// - Successful detection writes a 13-bit reload value into the baud reload register.
// - Rate index 0..8 loads reload 002,005,00B,011,023,047,08F,11F,23F.
// - Detection overwrites frame mode and parity polarity per detected frame type.
// - One error event line plus three enabled error flags in control register.
// - Error event rises in the same cycle as the receive event.
// - Async framing check enabled and a stop bit low sets framing flag.
// - Async parity mode, check enabled, parity mismatch sets parity flag.
// - Overrun check enabled and unread previous character sets overrun flag.
// - Error flags stay set until software clears; the event line drops itself.
// - Every event output is active exactly two module clock periods.
// - Detection-complete event follows recognition of the second character.
module autobaud_rx_check #(
	parameter int EVENT_LEN = `EVENT_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [`AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [`AXI_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Detector result, pulse after the second character
	input wire logic det_valid,
	input wire logic [`IDX_W-1:0] det_index,
	input wire logic [2:0] det_frame,
	// Receiver frame completion
	input wire logic rx_frame_done,
	input wire logic [`RX_W-1:0] rx_data,
	input wire logic rx_parity_bit,
	input wire logic rx_stop_ok,
	input wire logic rx_dma_ack,
	// Channel settings
	output logic [2:0] frame_mode,
	output logic parity_odd,
	output logic [`BG_W-1:0] baud_reload_value,
	output logic [`FDV_W-1:0] fractional_divide_field,
	// Events and interrupt
	output logic receive_done_event,
	output logic error_event_line,
	output logic detect_done_event,
	output logic irq
);
	autobaud_pkg::core_state_t q;
	autobaud_pkg::core_state_t d;
	logic [`BG_W-1:0] map_reload;
	logic [`DF_W-1:0] map_df;
	logic [2:0] map_mode;
	logic map_odd;
	logic map_valid;
	logic det_trig;
	logic err_trig;
	logic fe_hit;
	logic pe_hit;
	logic oe_hit;

	if (EVENT_LEN < 1 || EVENT_LEN > 15) begin : g_bad_len
		$error("autobaud_rx_check: EVENT_LEN out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge of a write into an old register value
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
			begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// Write-one-to-clear of sticky bits under byte lanes
	function automatic logic [31:0] w1c(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		return old & ~(nw & wmerge(32'h00000000, 32'hFFFFFFFF, st));
	endfunction : w1c

	////////////////////////////////////////////////////////////////////////////////
	// Detection result lookup
	detect_result_map u_map (
		.rate_index(det_index),
		.frame(det_frame),
		.reload(map_reload),
		.divide_factor(map_df),
		.mode(map_mode),
		.odd(map_odd),
		.valid(map_valid)
	);

	assign det_trig = det_valid && map_valid;

	////////////////////////////////////////////////////////////////////////////////
	// Receive error checks against the current control settings
	logic async_mode;
	logic parity_mode;
	logic seven_bit;
	logic exp_parity;
	logic rbuf_taken;

	assign async_mode = q.con[`CON_M_MSB:`CON_M_LSB] != `M_SYNC;
	assign parity_mode = q.con[`CON_M_MSB:`CON_M_LSB] == `M_7P
		|| q.con[`CON_M_MSB:`CON_M_LSB] == `M_8P;
	assign seven_bit = q.con[`CON_M_MSB:`CON_M_LSB] == `M_7P;
	assign exp_parity = (seven_bit ? ^rx_data[6:0] : ^rx_data[7:0]) ^ q.con[`CON_ODD];
	assign rbuf_taken = rx_dma_ack || (arvalid && arready && araddr == `OFS_RBUF);
	assign fe_hit = q.con[`CON_FEN] && async_mode && !rx_stop_ok;
	assign pe_hit = q.con[`CON_PEN] && async_mode && parity_mode
		&& (rx_parity_bit != exp_parity);
	assign oe_hit = q.con[`CON_OEN] && q.rbuf_full && !rbuf_taken;
	assign err_trig = rx_frame_done && (fe_hit || pe_hit || oe_hit);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic [31:0] rd;
		logic [31:0] nv;
		logic [1:0] rr;
		rd = 32'h00000000;
		nv = 32'h00000000;
		rr = `RESP_OKAY;
		d = q;

		// Write address and data may arrive in either order
		if (awvalid && awready)
		begin
			d.aw_got = 1'b1;
			d.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			d.w_got = 1'b1;
			d.wdata = wdata;
			d.wstrb = wstrb;
		end
		if (q.bvalid && bready)
		begin
			d.bvalid = 1'b0;
		end
		if (q.aw_got && q.w_got && !q.bvalid)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `RESP_OKAY;
			case (q.aw_addr)
				`OFS_CON:
				begin
					nv = w1c({16'h0000, q.con}, q.wdata, q.wstrb) & 32'(`CON_FLAGS);
					nv = nv | (wmerge({16'h0000, q.con}, q.wdata, q.wstrb)
						& ~32'(`CON_FLAGS));
					d.con = nv[`CON_W-1:0];
				end
				`OFS_BG:
				begin
					nv = wmerge({19'h00000, q.bg}, q.wdata, q.wstrb);
					d.bg = nv[`BG_W-1:0];
				end
				`OFS_FDV:
				begin
					nv = wmerge({23'h000000, q.fractional_divide_value}, q.wdata, q.wstrb);
					d.fractional_divide_value = nv[`FDV_W-1:0];
				end
				`OFS_IST:
				begin
					nv = w1c({29'h00000000, q.ist}, q.wdata, q.wstrb);
					d.ist = nv[`IRQ_W-1:0];
				end
				`OFS_IMASK:
				begin
					nv = wmerge({29'h00000000, q.imask}, q.wdata, q.wstrb);
					d.imask = nv[`IRQ_W-1:0];
				end
				`OFS_RBUF, `OFS_DET:
				begin
					d.bresp = `RESP_OKAY;
				end
				default:
				begin
					d.bresp = `RESP_SLVERR;
				end
			endcase
		end

		// Reads, with the receive buffer read releasing the buffer
		if (q.rvalid && rready)
		begin
			d.rvalid = 1'b0;
		end
		if (arvalid && arready)
		begin
			case (araddr)
				`OFS_CON: rd[`CON_W-1:0] = q.con;
				`OFS_BG: rd[`BG_W-1:0] = q.bg;
				`OFS_FDV: rd[`FDV_W-1:0] = q.fractional_divide_value;
				`OFS_RBUF: rd[`RX_W-1:0] = q.rbuf;
				`OFS_IST: rd[`IRQ_W-1:0] = q.ist;
				`OFS_IMASK: rd[`IRQ_W-1:0] = q.imask;
				`OFS_DET:
				begin
					rd[`IDX_W-1:0] = q.det_idx;
					rd[`DET_DF_LSB +: `DF_W] = q.det_df;
				end
				default: rr = `RESP_SLVERR;
			endcase
			d.rvalid = 1'b1;
			d.rdata = rd;
			d.rresp = rr;
		end
		if (rbuf_taken)
		begin
			d.rbuf_full = 1'b0;
		end

		// Completed frame: store, mark full, set enabled error flags
		if (rx_frame_done)
		begin
			d.rbuf = rx_data;
			d.rbuf_full = 1'b1;
			if (fe_hit)
			begin
				d.con[`CON_FE] = 1'b1;
			end
			if (pe_hit)
			begin
				d.con[`CON_PE] = 1'b1;
			end
			if (oe_hit)
			begin
				d.con[`CON_OE] = 1'b1;
			end
			d.ist[`IRQ_RX] = 1'b1;
		end
		if (err_trig)
		begin
			d.ist[`IRQ_ERR] = 1'b1;
		end

		// Detection result overwrites mode, polarity, reload, detected index and divide factor, and sets detect status
		if (det_trig)
		begin
			d.con[`CON_M_MSB:`CON_M_LSB] = map_mode;
			d.con[`CON_ODD] = map_odd;
			d.bg = map_reload;
			d.det_idx = det_index;
			d.det_df = map_df;
			d.ist[`IRQ_DET] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.con <= `CON_RST;
			q.bg <= `BG_RST;
			q.fractional_divide_value <= `FDV_RST;
			q.rbuf <= `RX_RST;
			q.ist <= `IRQ_RST;
			q.imask <= `IRQ_RST;
		end
		else
		begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event outputs, each held for EVENT_LEN clocks
	event_stretch #(.LEN(EVENT_LEN)) u_rx_ev (
		.aclk(aclk),
		.aresetn(aresetn),
		.trig(rx_frame_done),
		.ev(receive_done_event)
	);

	event_stretch #(.LEN(EVENT_LEN)) u_err_ev (
		.aclk(aclk),
		.aresetn(aresetn),
		.trig(err_trig),
		.ev(error_event_line)
	);

	event_stretch #(.LEN(EVENT_LEN)) u_det_ev (
		.aclk(aclk),
		.aresetn(aresetn),
		.trig(det_trig),
		.ev(detect_done_event)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign awready = !q.aw_got && !q.bvalid;
	assign wready = !q.w_got && !q.bvalid;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = !q.rvalid;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign frame_mode = q.con[`CON_M_MSB:`CON_M_LSB];
	assign parity_odd = q.con[`CON_ODD];
	assign baud_reload_value = q.bg;
	assign fractional_divide_field = q.fractional_divide_value;
	assign irq = |(q.ist & q.imask);
endmodule : autobaud_rx_check
`default_nettype wire

// file: tb/autobaud_rx_check_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
module autobaud_rx_check_properties #(
	parameter int EVENT_LEN = `EVENT_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Observed ports
	input wire logic bvalid,
	input wire logic det_valid,
	input wire logic [`IDX_W-1:0] det_index,
	input wire logic [2:0] det_frame,
	input wire logic rx_frame_done,
	input wire logic [2:0] frame_mode,
	input wire logic parity_odd,
	input wire logic [`BG_W-1:0] baud_reload_value,
	input wire logic receive_done_event,
	input wire logic error_event_line,
	input wire logic detect_done_event
);
	logic det_ok;
	assign det_ok = det_valid && det_index < 4'h9 && det_frame < 3'h5;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [`BG_W-1:0] rl(input logic [`IDX_W-1:0] i);
		case (i)
			4'h0: return `BG_BR0;
			4'h1: return `BG_BR1;
			4'h2: return `BG_BR2;
			4'h3: return `BG_BR3;
			4'h4: return `BG_BR4;
			4'h5: return `BG_BR5;
			4'h6: return `BG_BR6;
			4'h7: return `BG_BR7;
			default: return `BG_BR8;
		endcase
	endfunction : rl
	// Mode and odd bit as {mode, odd}
	function automatic logic [3:0] md(input logic [2:0] f);
		case (f)
			3'h0: return 4'h6;
			3'h1: return 4'h7;
			3'h2: return 4'hE;
			3'h3: return 4'hF;
			default: return 4'h2;
		endcase
	endfunction : md
	sequence s_det;
		det_ok;
	endsequence
	sequence s_two(e);
		e [*2];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_rx_event_len: assert property (rx_frame_done |=> s_two(receive_done_event))
		else $error("receive event not two cycles");
	a_rx_event_end: assert property (receive_done_event |-> $past(rx_frame_done) ||
		$past(rx_frame_done, 2)) else $error("receive event too long");
	a_err_with_rx: assert property (error_event_line |-> receive_done_event)
		else $error("error event without receive event");
	a_det_event_len: assert property (s_det |=> s_two(detect_done_event))
		else $error("detect event missing");
	a_det_event_end: assert property (detect_done_event |-> $past(det_ok) ||
		$past(det_ok, 2)) else $error("detect event too long");
	a_det_reload: assert property (s_det |=> baud_reload_value == rl($past(det_index)))
		else $error("wrong reload after detection");
	a_det_mode: assert property (s_det |=> {frame_mode, parity_odd} == md($past(det_frame)))
		else $error("wrong mode after detection");
	a_mode_cause: assert property ($changed({frame_mode, parity_odd}) |-> $past(det_ok) ||
		$rose(bvalid)) else $error("mode changed without cause");
endmodule : autobaud_rx_check_properties
bind autobaud_rx_check autobaud_rx_check_properties #(.EVENT_LEN(EVENT_LEN)) i_props (
	.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .det_valid(det_valid),
	.det_index(det_index), .det_frame(det_frame), .rx_frame_done(rx_frame_done),
	.frame_mode(frame_mode), .parity_odd(parity_odd), .baud_reload_value(baud_reload_value),
	.receive_done_event(receive_done_event), .error_event_line(error_event_line),
	.detect_done_event(detect_done_event));
`default_nettype wire

// file: tb/serial_front_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
module serial_front_model (
	// Clock
	input wire logic aclk,
	// Detector result
	output logic det_valid,
	output logic [`IDX_W-1:0] det_index,
	output logic [2:0] det_frame,
	// Received frame
	output logic rx_frame_done,
	output logic [`RX_W-1:0] rx_data,
	output logic rx_parity_bit,
	output logic rx_stop_ok,
	output logic rx_dma_ack
);
	initial
	begin
		{det_valid, det_index, det_frame, rx_frame_done} = '0;
		{rx_data, rx_parity_bit, rx_stop_ok, rx_dma_ack} = '0;
	end
	// Only "at" or "AT" give a result; released lines show the inverse
	task automatic detect(input logic [3:0] i, input logic [2:0] f);
		@(posedge aclk);
		det_valid <= 1'b1;
		det_index <= i;
		det_frame <= f;
		@(posedge aclk);
		det_valid <= 1'b0;
		det_index <= ~i;
		det_frame <= ~f;
	endtask : detect
	task automatic frame(input logic [8:0] v, input logic p, input logic s);
		@(posedge aclk);
		rx_frame_done <= 1'b1;
		rx_data <= v;
		rx_parity_bit <= p;
		rx_stop_ok <= s;
		@(posedge aclk);
		rx_frame_done <= 1'b0;
		rx_data <= ~v;
		rx_parity_bit <= ~p;
		rx_stop_ok <= ~s;
	endtask : frame
	task automatic dma();
		@(posedge aclk);
		rx_dma_ack <= 1'b1;
		@(posedge aclk);
		rx_dma_ack <= 1'b0;
	endtask : dma
endmodule : serial_front_model
`default_nettype wire

// file: tb/tb_autobaud_rx_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
module tb_autobaud_rx_check;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, det_valid, rx_frame_done, rx_parity_bit;
	logic rx_stop_ok, rx_dma_ack, parity_odd, receive_done_event, error_event_line;
	logic detect_done_event, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] det_index;
	logic [2:0] det_frame, frame_mode;
	logic [8:0] rx_data, fractional_divide_field;
	logic [12:0] baud_reload_value;
	logic [12:0] er = 13'h0000;
	logic [12:0] rl [9] = '{13'h002, 13'h005, 13'h00B, 13'h011, 13'h023, 13'h047, 13'h08F,
		13'h11F, 13'h23F};
	logic [13:0] df [9] = '{14'h0030, 14'h0060, 14'h00C0, 14'h0120, 14'h0240, 14'h0480,
		14'h0900, 14'h1200, 14'h2400};
	// Control layout {odd, mode} per detected frame kind
	logic [3:0] md [5] = '{4'h3, 4'hB, 4'h7, 4'hF, 4'h1};
	int errors = 0;
	int n_compared = 0;
	int seed = 32'h38BAECB6;
	int ctrl = 0;
	int full = 0;
	int rxq[$];
	int ex, d, f;
	logic p;
	autobaud_rx_check #(.EVENT_LEN(2)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.det_valid(det_valid), .det_index(det_index), .det_frame(det_frame),
		.rx_frame_done(rx_frame_done), .rx_data(rx_data), .rx_parity_bit(rx_parity_bit),
		.rx_stop_ok(rx_stop_ok), .rx_dma_ack(rx_dma_ack), .frame_mode(frame_mode),
		.parity_odd(parity_odd), .baud_reload_value(baud_reload_value),
		.fractional_divide_field(fractional_divide_field),
		.receive_done_event(receive_done_event), .error_event_line(error_event_line),
		.detect_done_event(detect_done_event), .irq(irq)
	);
	serial_front_model i_far (
		.aclk(aclk), .det_valid(det_valid), .det_index(det_index), .det_frame(det_frame),
		.rx_frame_done(rx_frame_done), .rx_data(rx_data), .rx_parity_bit(rx_parity_bit),
		.rx_stop_ok(rx_stop_ok), .rx_dma_ack(rx_dma_ack)
	);
	initial
	begin
		forever #20 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		while (bvalid !== 1'b1)
			@(posedge aclk);
		bready <= 1'b0;
		chk("write response", (a > 8'h18) ? 2 : 0, bresp);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk($sformatf("read data at %h", a), e, rdata);
		chk("read response", (a > 8'h18) ? 2 : 0, rresp);
	endtask : rd
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (20000) @(posedge aclk);
		errors++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 0);
		rd(8'h04, 0);
		wr(8'h08, 32'h0E2);
		rd(8'h08, 32'h0E2);
		chk("divider port", 32'h0E2, fractional_divide_field);
		wr(8'h00, 32'h5A5AF8F0);
		ctrl = 32'hF8F0;
		rd(8'h00, ctrl);
		for (int i = 0; i < 11; i++)
		begin
			f = i % 5;
			i_far.detect((i == 10) ? 4'h0 : i[3:0], (i == 10) ? 3'h5 : f[2:0]);
			if (i < 9)
			begin
				ctrl = (ctrl & 32'hFFF0) | md[f];
				er = rl[i];
			end
			#1;
			chk("detect event", i < 9, detect_done_event);
			chk("reload port", er, baud_reload_value);
			chk("mode port", ctrl & 32'hF, {parity_odd, frame_mode});
			rd(8'h00, ctrl);
			if (i < 9)
				rd(8'h18, {2'b00, df[i], 12'h000, i[3:0]});
		end
		for (int j = 0; j < 4; j++)
		begin
			d = $random(seed) & 32'h1FF;
			rxq.push_back(d);
			p = ^d[7:0] ^ 1'b1 ^ (j == 2);
			i_far.frame(d[8:0], p, j != 3);
			ex = (full != 0) ? 32'h400 : 0;
			ex |= (j == 2) ? 32'h200 : 0;
			ex |= (j == 3) ? 32'h100 : 0;
			ctrl |= ex;
			full = 1;
			#1;
			chk("receive event", 1, receive_done_event);
			chk("error event", ex != 0, error_event_line);
			repeat (2) @(posedge aclk);
			#1;
			chk("receive event end", 0, receive_done_event);
			chk("error event end", 0, error_event_line);
			if (j == 1)
				rd(8'h0C, rxq[$]);
			if (j == 2)
				i_far.dma();
			if (j == 1 || j == 2)
				full = 0;
		end
		rd(8'h00, ctrl);
		rd(8'h10, 7);
		chk("irq masked", 0, irq);
		wr(8'h14, 7);
		chk("irq", 1, irq);
		wr(8'h00, ctrl);
		ctrl &= 32'hF8FF;
		rd(8'h00, ctrl);
		wr(8'h10, 3);
		rd(8'h10, 4);
		chk("irq detect", 1, irq);
		wr(8'h14, 3);
		chk("irq detect masked", 0, irq);
		wr(8'h10, 4);
		rd(8'h10, 0);
		rd(8'h0C, rxq[$]);
		wr(8'h00, 32'h00F3);
		d = $random(seed) & 32'h1FF;
		i_far.frame(d[8:0], ~^d[6:0], 1'b1);
		#1;
		chk("error event 7-bit parity", 1, error_event_line);
		rd(8'h00, 32'h02F3);
		wr(8'h00, 32'h0270);
		i_far.frame(d[8:0], ~^d[7:0], 1'b0);
		#1;
		chk("error event sync overrun", 1, error_event_line);
		rd(8'h00, 32'h0470);
		wr(8'h04, 32'hFFFF1ABC);
		rd(8'h04, 32'h1ABC);
		chk("reload rewrite", 32'h1ABC, baud_reload_value);
		wr(8'h1C, 0);
		rd(8'h1C, 0);
		tally_and_finish();
	end
endmodule : tb_autobaud_rx_check
`default_nettype wire
